/* sim/reset_pin_driver.sv */
// outside circuit pulling the reset pin low for a set count
// assumes a pull-up, so a released pin reads high
`timescale 1ns/100ps
module reset_pin_driver (
  input wire clk,
  input wire go,
  input wire [3:0] lowLen,
  input wire devOe,
  input wire devOut,
  output wire pinLevel
);
  reg [3:0] left_q = 4'h0;
  // ====
  // low time counter
  always @(posedge clk)
    left_q <= go ? lowLen : left_q - {3'h0, left_q != 4'h0};
  // open drain with pull-up: low while either side pulls it low
  assign pinLevel = (left_q == 4'h0) && !(devOe && !devOut);
endmodule

/* sim/reset_sources_checker.sv */
// checker for the reset source block outputs
// assumes a bind to the block; one clock, async reset
`timescale 1ns/100ps
module reset_sources_checker (
  input wire clk, rst, resetPinIn, resetPinOut, resetPinOe, systemReset,
  input wire watchdogTimeout, watchdogResetSelect, watchdogIrq, watchdogCauseFlag,
  input wire stopMode, brownoutStopKeepOn, brownoutEnable, debugDriveLow,
  input wire debugLineOut, debugLineOe, externalClockSelect, externalClockUse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // assertions
  a_pin_driven: assert property (systemReset |-> resetPinOe && !resetPinOut)
    else $error("pin not low");
  a_pin_starts: assert property ((!resetPinIn && !resetPinOe) [*4] |-> ##[1:8] systemReset)
    else $error("pin low ignored");
  a_wdt_reset: assert property (watchdogTimeout && watchdogResetSelect
    |=> systemReset && watchdogCauseFlag) else $error("no wdt reset");
  a_wdt_irq: assert property (watchdogTimeout && !watchdogResetSelect |=> watchdogIrq)
    else $error("no wdt irq");
  a_bo_follow: assert property (if (stopMode && !brownoutStopKeepOn) ##1 !brownoutEnable
    else ##1 brownoutEnable) else $error("bad bo enable");
  a_dbg_low: assert property (debugDriveLow |=> debugLineOe && !debugLineOut)
    else $error("debug not low");
  a_clk_sel: assert property (if (externalClockSelect) ##1 externalClockUse
    else ##1 !externalClockUse) else $error("bad clock use");
  // a short sequence would let the core run before sources settle
  a_seq_len: assert property ($rose(systemReset) |-> systemReset [*8])
    else $error("reset too short");
  cover property (watchdogIrq);
  cover property (watchdogCauseFlag);
  cover property (stopMode && !brownoutEnable);
endmodule
bind system_reset_sources reset_sources_checker chk (.*);

/* sim/system_reset_sources_tb.sv */
// self-checking bench for the reset source block
// assumes the pin driver and the bound checker
`timescale 1ns/100ps
module system_reset_sources_tb;
  logic clk = 0, rst = 1, go = 0, brownoutDetect = 0, causeClear = 0;
  logic watchdogTimeout = 0, watchdogResetSelect = 1, stopMode = 0, debugLineIn = 1;
  logic brownoutStopKeepOn = 0, externalClockSelect = 0, debugDriveLow = 0;
  logic [3:0] lowLen = 4'h0;
  logic [5:0] r;
  logic [1:0] dHist;
  wire resetPinIn, resetPinOut, resetPinOe, externalClockUse, debugLineOut, debugLineOe;
  wire debugLineSeen, systemReset, watchdogIrq, brownoutEnable, watchdogCauseFlag;
  integer bad_count = 0, n_compared = 0, seed = 12114, i;
  system_reset_sources DUT (.*);
  reset_pin_driver partner (.clk(clk), .go(go), .lowLen(lowLen), .devOe(resetPinOe),
    .devOut(resetPinOut), .pinLevel(resetPinIn));
  initial forever #2 clk = ~clk;
  // ====
  // tasks
  function logic boEn(input logic s, input logic k);
    return !s || k;
  endfunction
  task chk(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task waitRst(input logic v);
    for (i = 0; i < 40 && systemReset !== v; i++) tick;
    chk(systemReset, v);
    if (systemReset !== v) test_done;
  endtask
  // one cycle of watchdog pulse and/or a pin low of n cycles
  task kick(input logic t, input logic s, input logic [3:0] n);
    @(posedge clk);
    watchdogTimeout <= t;
    watchdogResetSelect <= s;
    go <= (n != 4'h0);
    lowLen <= n;
    @(posedge clk);
    watchdogTimeout <= 0;
    go <= 0;
    #1;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    waitRst(0);
    chk(watchdogCauseFlag, 0);
    kick(0, 1, 4'h3);
    repeat (12) tick;
    chk(systemReset, 0);
    kick(0, 1, 4'h4);
    waitRst(1);
    chk(resetPinOe, 1);
    chk(resetPinOut, 0);
    waitRst(0);
    kick(1, 1, 4'h0);
    chk(systemReset, 1);
    chk(watchdogCauseFlag, 1);
    waitRst(0);
    kick(1, 0, 4'h0);
    chk(watchdogIrq, 1);
    chk(systemReset, 0);
    dHist = 2'h3;
    repeat (60) begin
      @(posedge clk);
      r = 6'($random(seed));
      {causeClear, debugLineIn, debugDriveLow} <= r[5:3];
      {externalClockSelect, brownoutStopKeepOn, stopMode} <= r[2:0];
      tick;
      chk(brownoutEnable, boEn(r[0], r[1]));
      chk(externalClockUse, r[2]);
      chk(debugLineOe, r[3]);
      chk(debugLineSeen, dHist[1]);
      dHist = {dHist[0], r[4]};
    end
    // clear, then a watchdog set against a standing clear: the set wins
    @(posedge clk);
    causeClear <= 1;
    repeat (3) tick;
    chk(watchdogCauseFlag, 0);
    kick(1, 1, 4'h0);
    tick;
    chk(watchdogCauseFlag, 1);
    @(posedge clk);
    causeClear <= 0;
    waitRst(0);
    // brown-out in stop mode only resets when kept on
    @(posedge clk);
    {stopMode, brownoutStopKeepOn, brownoutDetect} <= 3'b101;
    repeat (4) tick;
    chk(systemReset, 0);
    @(posedge clk);
    brownoutStopKeepOn <= 1;
    waitRst(1);
    @(posedge clk);
    brownoutDetect <= 0;
    waitRst(0);
    test_done;
  end
endmodule

/* src/reset_sources_consts.vh */
// named constants for the system reset source block
// assumes inclusion by bare name from the block's source file
`ifndef RESET_SOURCES_CONSTS_VH
`define RESET_SOURCES_CONSTS_VH
// least low time of the reset pin, in system clock periods
`define PIN_LOW_MIN_CYCLES 4
`define PIN_CNT_W 3
`define PIN_CNT_ZERO 3'h0
// idle level of a pin synchroniser: all stages high, pins idle high
`define PIN_SYNC_IDLE 3'h7
// length of the internal reset sequence once a source is seen
`define SEQ_CYCLES 8
`define SEQ_CNT_W 4
`define SEQ_CNT_ZERO 4'h0
// erased value of the watchdog reset option
`define WDT_RESET_ERASED 1'b1
`endif

/* src/system_reset_sources.v */
// system reset sources: reset pin, watchdog time-out, brown-out (in stop mode only when kept on)
// assumes option bits are stable levels from nonvolatile storage and that
// the watchdog, brown-out, clock select and debugger logic live elsewhere
//
// How it works
// - a low on the external reset pin starts a system reset
// - the reset pin is pulled low while any reset is in progress
// - pin must stay low four clocks before the reset sequence runs
// - stop-mode brown-out enable follows the always-on option bit
// - watchdog time-out resets the system when its option bit reads 1
// - with the option at 0 a watchdog time-out raises an interrupt instead
// - a watchdog-caused reset sets the watchdog cause flag to 1
// - the debug line is only ever driven low, else released
// - an external clock input may be selected as the system clock
`timescale 1ns/100ps
`include "reset_sources_consts.vh"

module system_reset_sources (
  // clock and reset
  input wire clk,
  input wire rst,
  // reset pin, open drain
  input wire resetPinIn,
  output reg resetPinOut,
  output reg resetPinOe,
  // option bits
  input wire brownoutStopKeepOn,
  input wire watchdogResetSelect,
  // power state and sources
  input wire stopMode,
  input wire brownoutDetect,
  input wire watchdogTimeout,
  // clock select
  input wire externalClockSelect,
  output reg externalClockUse,
  // debugger line, open drain
  input wire debugLineIn,
  input wire debugDriveLow,
  output reg debugLineOut,
  output reg debugLineOe,
  output reg debugLineSeen,
  // status towards the core
  input wire causeClear,
  output reg systemReset,
  output reg watchdogIrq,
  output reg brownoutEnable,
  output reg watchdogCauseFlag
);

  // ==========================================================
  // state codes
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_RESET = 2'b10;

  // sequencer state
  reg [1:0] state_q;
  reg [1:0] state_d;

  // input synchronisers, three stages each
  reg [2:0] pinSync_q;
  reg pinLow_q;
  reg [2:0] dbgSync_q;

  // counters and the sticky cause
  reg [`PIN_CNT_W-1:0] lowCnt_q;
  reg [`SEQ_CNT_W-1:0] seqCnt_q;
  reg wdtCause_q;

  // ==========================================================
  // helpers
  // a synchronised level only counts once the last two stages agree
  function stagesAgree;
    input [2:0] stages;
    begin
      stagesAgree = stages[1] == stages[2];
    end
  endfunction

  // ==========================================================
  // source decode
  wire pinAgree = stagesAgree(pinSync_q);
  wire pinLowNow = pinAgree ? ~pinSync_q[2] : pinLow_q;
  wire pinQualified = pinLowNow && (lowCnt_q >= `PIN_LOW_MIN_CYCLES - 1);
  wire wdtReset = watchdogTimeout && watchdogResetSelect;
  // brown-out only counts in stop mode when kept on
  wire brownoutEn = ~stopMode | brownoutStopKeepOn;
  wire bodReset = brownoutDetect && brownoutEn;
  wire anySource = pinQualified | wdtReset | bodReset;

  // ==========================================================
  // pin sampling: three stages, a change counts when the last two agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync_q <= `PIN_SYNC_IDLE;
      dbgSync_q <= `PIN_SYNC_IDLE;
      pinLow_q <= 1'b0;
    end else begin
      // our own pull is masked, else the low we force would hold us in reset
      pinSync_q <= {pinSync_q[1:0], resetPinIn | resetPinOe};
      dbgSync_q <= {dbgSync_q[1:0], debugLineIn};
      pinLow_q <= pinLowNow;
    end
  end

  // ==========================================================
  // low-time counter, saturates at the qualifying count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt_q <= `PIN_CNT_ZERO;
    end else if (!pinLowNow) begin
      lowCnt_q <= `PIN_CNT_ZERO;
    end else if (!pinQualified) begin
      lowCnt_q <= lowCnt_q + 1'b1;
    end
  end

  // ==========================================================
  // reset sequencer; leaves reset once the sequence count ends, as our own pull masks a pin still held low
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (anySource) begin
          state_d = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!anySource && !pinLowNow && seqCnt_q == `SEQ_CYCLES - 1) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
      seqCnt_q <= `SEQ_CNT_ZERO;
    end else begin
      state_q <= state_d;
      // sequence restarts on any new source so the full length always runs
      if (state_q == ST_RUN || anySource) begin
        seqCnt_q <= `SEQ_CNT_ZERO;
      end else if (seqCnt_q != `SEQ_CYCLES - 1) begin
        seqCnt_q <= seqCnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // cause flag: a new watchdog reset wins over a clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdtCause_q <= 1'b0;
    end else if (wdtReset) begin
      wdtCause_q <= 1'b1;
    end else if (causeClear) begin
      wdtCause_q <= 1'b0;
    end
  end

  // ==========================================================
  // reset pin and core reset, both from the next state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b1;
      systemReset <= 1'b1;
    end else begin
      resetPinOut <= 1'b0;
      resetPinOe <= state_d == ST_RESET;
      systemReset <= state_d == ST_RESET;
    end
  end

  // ==========================================================
  // watchdog outputs
  // a set shows at once; a clear shows one cycle late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdogIrq <= 1'b0;
      watchdogCauseFlag <= 1'b0;
    end else begin
      watchdogIrq <= watchdogTimeout && !watchdogResetSelect;
      watchdogCauseFlag <= wdtReset | wdtCause_q;
    end
  end

  // ==========================================================
  // power and clock selection outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      brownoutEnable <= 1'b1;
      externalClockUse <= 1'b0;
    end else begin
      brownoutEnable <= brownoutEn;
      externalClockUse <= externalClockSelect;
    end
  end

  // ==========================================================
  // debug line: only ever pulled low, the pull-up makes the high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      debugLineOut <= 1'b0;
      debugLineOe <= 1'b0;
      debugLineSeen <= 1'b1;
    end else begin
      debugLineOut <= 1'b0;
      debugLineOe <= debugDriveLow;
      if (stagesAgree(dbgSync_q)) begin
        debugLineSeen <= dbgSync_q[2];
      end
    end
  end

endmodule
